// ### logic/sarcs_pkg.sv
// ============================================================
// Shared constants for the successive-approximation sequencer.
// ============================================================
package sarcs_pkg;

    // ========================================================
    // Register port geometry and register map.
    // ========================================================
    localparam int          ADDR_W     = 4;       // Register address width.
    localparam int          DATA_W     = 8;       // Register data width.
    localparam logic [3:0]  REG_CTRL   = 4'h0;    // converter_control.
    localparam logic [3:0]  REG_RESULT = 4'h1;    // conversion_result.
    localparam logic [3:0]  REG_FLAG   = 4'h2;    // periph_flag_reg_1.
    localparam logic [3:0]  REG_IEN    = 4'h3;    // periph_enable_reg_1.

    // ========================================================
    // Field positions and reset values.
    // ========================================================
    localparam int          CS_MSB     = 7;       // Clock select top bit.
    localparam int          CS_LSB     = 5;       // Clock select low bit.
    localparam int          CH_MSB     = 4;       // Channel select top bit.
    localparam int          CH_LSB     = 2;       // Channel select low bit.
    localparam int          GO_BIT     = 1;       // Start/done bit.
    localparam int          EN_BIT     = 0;       // converter_enable bit.
    localparam int          IRQ_BIT    = 6;       // Flag and enable position.
    localparam logic [7:0]  CTRL_RST   = 8'h00;   // Control reset value.
    localparam logic [7:0]  ZERO_BYTE  = 8'h00;   // Reads of empty bits.

    // ========================================================
    // Clock select and channel select encodings.
    // ========================================================
    localparam logic [2:0]  CS_DIV2    = 3'h0;    // Fosc/2.
    localparam logic [2:0]  CS_DIV8    = 3'h1;    // Fosc/8.
    localparam logic [2:0]  CS_DIV32   = 3'h2;    // Fosc/32.
    localparam logic [2:0]  CS_DIV4    = 3'h4;    // Fosc/4.
    localparam logic [2:0]  CS_DIV16   = 3'h5;    // Fosc/16.
    localparam logic [2:0]  CS_DIV64   = 3'h6;    // Fosc/64.
    localparam logic [1:0]  CS_RC_LOW  = 2'h3;    // x11 picks the RC clock.
    localparam logic [2:0]  CH_AN0     = 3'h0;    // analog_input_0.
    localparam logic [2:0]  CH_AN1     = 3'h1;    // analog_input_1.
    localparam logic [2:0]  CH_AN2     = 3'h2;    // analog_input_2.
    localparam logic [2:0]  CH_TEMP    = 3'h6;    // Temperature indicator.
    localparam logic [2:0]  CH_FVR     = 3'h7;    // fixed_reference_buffer.

    // ========================================================
    // Timing.
    // ========================================================
    localparam int          CLK_PERIOD_NS = 40;   // System clock, 25 MHz.
    localparam int          INSTR_NS      = 160;  // One instruction cycle.
    localparam int          INSTR_CLKS    =
        (INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0]  INSTR_CNT_MAX = 3'(INSTR_CLKS - 1);
    localparam logic [4:0]  ACQ_HALF   = 5'h03;   // Half periods of sampling.
    localparam logic [4:0]  FIRST_DEC  = 5'h05;   // Half period of first bit.
    localparam logic [4:0]  TOTAL_HALF = 5'h13;   // 9.5 periods = 19 halves.
    localparam logic [7:0]  SAR_MSB    = 8'h80;   // First trial bit.

    // True when the select field picks the dedicated RC clock.
    function automatic logic is_rc(input logic [2:0] sel);
        is_rc = (sel[1:0] == CS_RC_LOW);
    endfunction

    // System clocks per half conversion period, minus one.
    function automatic logic [4:0] half_div(input logic [2:0] sel);
        case (sel)
            CS_DIV2:  half_div = 5'h00;
            CS_DIV4:  half_div = 5'h01;
            CS_DIV8:  half_div = 5'h03;
            CS_DIV16: half_div = 5'h07;
            CS_DIV32: half_div = 5'h0F;
            CS_DIV64: half_div = 5'h1F;
            default:  half_div = 5'h00;
        endcase
    endfunction

    // One-hot routing: an0, an1, an2, temperature, reference.
    function automatic logic [4:0] chan_route(input logic [2:0] ch);
        case (ch)
            CH_AN0:  chan_route = 5'h01;
            CH_AN1:  chan_route = 5'h02;
            CH_AN2:  chan_route = 5'h04;
            CH_TEMP: chan_route = 5'h08;
            CH_FVR:  chan_route = 5'h10;
            default: chan_route = 5'h00;
        endcase
    endfunction

    // Sequencer states.
    typedef enum logic [1:0] {SARCS_IDLE, SARCS_DELAY, SARCS_CONV} sarcs_st_t;

endpackage

// ### logic/sarcs_tad_gen.sv
`timescale 1ns/100ps
// ============================================================
// Half conversion period tick generator.
// ============================================================
module sarcs_tad_gen
    import sarcs_pkg::*;
(
    input  wire logic       clock,     // System clock.
    input  wire logic       srst,      // Synchronous reset.
    input  wire logic       run,       // High while converting.
    input  wire logic [2:0] sel,       // Conversion clock select.
    input  wire logic       rc_osc,    // Dedicated RC oscillator pin.
    output logic            half_tick  // One pulse per half period.
);

    logic [4:0] div_q;     // Divider count.
    logic       rc_s1_q;   // RC synchroniser first stage.
    logic       rc_s2_q;   // RC synchroniser second stage.
    logic       rc_s3_q;   // Delayed copy for edge detection.
    logic       rc_edge;   // Either edge of the RC clock.
    logic       div_wrap;  // Divider reached its end.

    assign rc_edge  = rc_s2_q ^ rc_s3_q;
    assign div_wrap = (div_q == half_div(sel));

    // Brings the RC clock into the system domain.
    always_ff @(posedge clock)
    begin
        rc_s1_q <= rc_osc;
        rc_s2_q <= rc_s1_q;
        rc_s3_q <= rc_s2_q;
    end

    // Divides the system clock; restarts at every conversion.
    always_ff @(posedge clock)
    begin
        if (srst || !run || div_wrap)
        begin
            div_q <= 5'h00;
        end
        else
        begin
            div_q <= div_q + 5'h01;
        end
    end

    // Each RC edge, or each divider wrap, marks half a period.
    always_comb
    begin
        if (!run)
        begin
            half_tick = 1'b0;
        end
        else if (is_rc(sel))
        begin
            half_tick = rc_edge;
        end
        else
        begin
            half_tick = div_wrap;
        end
    end

endmodule // sarcs_tad_gen

// ### logic/sarcs_sar_core.sv
`timescale 1ns/100ps
// ============================================================
// Successive-approximation bit engine.
// ============================================================
module sarcs_sar_core
    import sarcs_pkg::*;
(
    input  wire logic       clock,     // System clock.
    input  wire logic       srst,      // Synchronous reset.
    input  wire logic       start,     // Begin a conversion.
    input  wire logic       abort,     // Stop early, keep partial bits.
    input  wire logic       half_tick, // Half conversion period.
    input  wire logic       comp_in,   // Comparator pin, input above DAC.
    output logic            busy_q,    // Conversion running.
    output logic            sample_q,  // Sampling switch closed.
    output logic [7:0]      dac_q,     // Trial code to the DAC.
    output logic            done_q,    // Pulse: full result ready.
    output logic            part_q,    // Pulse: partial result ready.
    output logic [7:0]      res_q      // Result for either pulse.
);

    logic [4:0] half_q;    // Half periods seen so far.
    logic [7:0] cur_q;     // One-hot trial bit.
    logic       last_q;    // Value of the last resolved bit.
    logic       cmp_q;     // Registered comparator decision.
    logic [4:0] half_d;    // Next half period count.
    logic       decide;    // A bit is resolved now.
    logic [7:0] kept;      // Code with the current bit decided.
    logic [8:0] low_mask;  // Trial bit and all bits below it.
    logic [7:0] partial;   // Abort result.

    assign half_d   = half_q + 5'h01;
    assign decide   = half_tick && !sample_q && (half_d >= FIRST_DEC)
                      && half_d[0];
    assign kept     = cmp_q ? dac_q : (dac_q & ~cur_q);
    assign low_mask = {cur_q, 1'b0} - 9'h001;
    assign partial  = (dac_q & ~low_mask[7:0])
                      | (last_q ? low_mask[7:0] : ZERO_BYTE);

    // Registers the comparator decision. With the input held, it only
    // moves after our own trial code does, so one stage is enough; a
    // second would answer one trial late at the fastest conversion clock.
    always_ff @(posedge clock)
    begin
        cmp_q <= comp_in;
    end

    // Steps sampling, bit trials and the finish.
    always_ff @(posedge clock)
    begin
        done_q <= 1'b0;
        part_q <= 1'b0;
        if (srst)
        begin
            busy_q   <= 1'b0;
            sample_q <= 1'b0;
            half_q   <= 5'h00;
            cur_q    <= 8'h00;
            dac_q    <= 8'h00;
            last_q   <= 1'b0;
            res_q    <= 8'h00;
        end
        else if (start)
        begin
            busy_q   <= 1'b1;
            sample_q <= 1'b1;
            half_q   <= 5'h00;
            cur_q    <= SAR_MSB;
            dac_q    <= SAR_MSB;
            last_q   <= 1'b0;
        end
        else if (busy_q && abort)
        begin
            busy_q   <= 1'b0;
            sample_q <= 1'b0;
            part_q   <= 1'b1;
            res_q    <= partial;
        end
        else if (busy_q && half_tick)
        begin
            half_q <= half_d;
            if (half_d == ACQ_HALF)
            begin
                sample_q <= 1'b0;
            end
            if (decide)
            begin
                last_q <= cmp_q;
                cur_q  <= cur_q >> 1;
                dac_q  <= kept | (cur_q >> 1);
            end
            if (half_d == TOTAL_HALF)
            begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
                res_q  <= kept;
            end
        end
    end

endmodule // sarcs_sar_core

// ### logic/sarcs_top.sv
// Added by the designer: strobed register access and the address map.
`timescale 1ns/100ps
// ============================================================
// Converter sequencer top.
// ============================================================
module sarcs_top
    import sarcs_pkg::*;
(
    input  wire logic              clock,      // System clock, 25 MHz.
    input  wire logic              srst,       // Synchronous reset.
    input  wire logic [ADDR_W-1:0] addr,       // Register address.
    input  wire logic [DATA_W-1:0] wr_data,    // Register write data.
    input  wire logic              wr_en,      // Write strobe.
    input  wire logic              rd_en,      // Read strobe.
    output logic      [DATA_W-1:0] rd_data_q,  // Read data, next cycle.
    input  wire logic              sleep_mode, // Core is in sleep.
    input  wire logic              rc_osc,     // Dedicated RC clock pin.
    input  wire logic              comp_in,    // Comparator decision.
    output logic                   power_q,    // Analog power on.
    output logic      [4:0]        chan_q,     // One-hot channel switches.
    output logic                   sample_q,   // Sampling switch closed.
    output logic      [7:0]        dac_q,      // Trial code to DAC.
    output logic                   irq_q,      // Flag and enable both set.
    output logic                   wake_q      // Pulse: wake the core.
);

    // ========================================================
    // State.
    // ========================================================
    logic [2:0] cs_q;       // Conversion clock select.
    logic [2:0] ch_q;       // Channel select.
    logic       go_q;       // Start/done bit storage.
    logic       en_q;       // converter_enable.
    logic [7:0] result_q;   // conversion_result, no reset.
    logic       flag_q;     // conv_irq_flag.
    logic       ien_q;      // conv_irq_enable.
    logic       pdown_q;    // Powered down by sleep.
    logic       slp_q;      // Sleep level of last cycle.
    logic [2:0] icnt_q;     // Instruction delay counter.
    sarcs_st_t  st_q;       // Sequencer state.
    sarcs_st_t  st_d;       // Next sequencer state.

    // ========================================================
    // Decode.
    // ========================================================
    logic       wr_ctrl;    // Write to converter_control.
    logic       wr_res;     // Write to conversion_result.
    logic       wr_flag;    // Write to periph_flag_reg_1.
    logic       wr_ien;     // Write to periph_enable_reg_1.
    logic       sw_go;      // Start written while already enabled.
    logic       sw_stop;    // Start bit cleared or module disabled.
    logic       slp_rise;   // Sleep entered this cycle.
    logic       slp_fall;   // Sleep left this cycle.
    logic       rc_sel;     // RC clock selected.
    logic       sys_abort;  // Sleep with a system-derived clock.
    logic       busy;       // Core converting.
    logic       core_start; // Start pulse to the core.
    logic       core_abort; // Abort pulse to the core.
    logic       done;       // Core finished normally.
    logic       part;       // Core stopped early.
    logic [7:0] core_res;   // Core result.
    logic       half_tick;  // Half conversion period.
    logic       running;    // Divider runs.
    logic [7:0] ctrl_view;  // Control register as read.
    logic [7:0] rd_mux;     // Selected read data.

    assign wr_ctrl   = wr_en && (addr == REG_CTRL);
    assign wr_res    = wr_en && (addr == REG_RESULT);
    assign wr_flag   = wr_en && (addr == REG_FLAG);
    assign wr_ien    = wr_en && (addr == REG_IEN);
    assign sw_go     = wr_ctrl && wr_data[GO_BIT] && en_q;
    assign sw_stop   = wr_ctrl && (!wr_data[GO_BIT] || !wr_data[EN_BIT]);
    assign slp_rise  = sleep_mode && !slp_q;
    assign slp_fall  = !sleep_mode && slp_q;
    assign rc_sel    = is_rc(cs_q);
    assign sys_abort = slp_rise && !rc_sel && (st_q != SARCS_IDLE);
    assign core_abort = (sw_stop || sys_abort) && !done;
    assign running   = (st_q == SARCS_CONV);
    // start bit reads zero when disabled
    assign ctrl_view = {cs_q, ch_q, go_q && en_q, en_q};

    // Read multiplexer; unmapped addresses read zero.
    always_comb
    begin
        case (addr)
            REG_CTRL:   rd_mux = ctrl_view;
            REG_RESULT: rd_mux = result_q;
            REG_FLAG:   rd_mux = 8'(flag_q) << IRQ_BIT;
            REG_IEN:    rd_mux = 8'(ien_q) << IRQ_BIT;
            default:    rd_mux = ZERO_BYTE;
        endcase
    end

    // ========================================================
    // Sequencer.
    // ========================================================
    // Chooses the next state from start, delay and finish.
    always_comb
    begin
        st_d       = st_q;
        core_start = 1'b0;
        case (st_q)
            SARCS_IDLE:
            begin
                if (sw_go && !sw_stop)
                begin
                    st_d = rc_sel ? SARCS_DELAY : SARCS_CONV;
                    core_start = !rc_sel;
                end
            end
            SARCS_DELAY:
            begin
                if (core_abort)
                begin
                    st_d = SARCS_IDLE;
                end
                else if (icnt_q == INSTR_CNT_MAX)
                begin
                    st_d = SARCS_CONV;
                    core_start = 1'b1;
                end
            end
            SARCS_CONV:
            begin
                if (done || core_abort || (!busy && !core_start))
                begin
                    st_d = SARCS_IDLE;
                end
            end
            default:
            begin
                st_d = SARCS_IDLE;
            end
        endcase
    end

    // Holds state and counts the extra instruction cycle.
    always_ff @(posedge clock)
    begin
        slp_q <= sleep_mode;
        if (srst)
        begin
            st_q   <= SARCS_IDLE;
            icnt_q <= 3'h0;
        end
        else
        begin
            st_q   <= (st_q == SARCS_IDLE && st_d == SARCS_CONV)
                      ? SARCS_CONV : st_d;
            icnt_q <= (st_q == SARCS_DELAY) ? icnt_q + 3'h1 : 3'h0;
        end
    end

    // ========================================================
    // Control register.
    // ========================================================
    // Stores fields; hardware clears the start bit at the end.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            {cs_q, ch_q, go_q, en_q} <= CTRL_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                cs_q <= wr_data[CS_MSB:CS_LSB];
                ch_q <= wr_data[CH_MSB:CH_LSB];
                en_q <= wr_data[EN_BIT];
                // A start written beside a disable is dropped.
                go_q <= sw_go && !sw_stop;
            end
            if (done || sys_abort)
            begin
                go_q <= 1'b0;
            end
        end
    end

    // ========================================================
    // Result, flag and power.
    // ========================================================
    // Loads the result on finish or abort; software may write it.
    always_ff @(posedge clock)
    begin
        if (done || part)
        begin
            result_q <= core_res;
        end
        else if (wr_res)
        begin
            result_q <= wr_data;
        end
    end

    // Flag set beats a software clear in the same cycle.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            flag_q  <= 1'b0;
            ien_q   <= 1'b0;
            pdown_q <= 1'b0;
            wake_q  <= 1'b0;
            irq_q   <= 1'b0;
        end
        else
        begin
            if (wr_ien)
            begin
                ien_q <= wr_data[IRQ_BIT];
            end
            if (done)
            begin
                flag_q <= 1'b1;
            end
            else if (wr_flag)
            begin
                flag_q <= wr_data[IRQ_BIT];
            end
            wake_q <= done && sleep_mode && ien_q;
            irq_q  <= (flag_q || done) && ien_q;
            if ((done && sleep_mode && !ien_q) || sys_abort
                || (slp_rise && !rc_sel))
            begin
                pdown_q <= 1'b1;
            end
            else if (slp_fall)
            begin
                pdown_q <= 1'b0;
            end
        end
    end

    // Drives the analog switches and power from flip-flops.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            power_q   <= 1'b0;
            chan_q    <= 5'h00;
            rd_data_q <= ZERO_BYTE;
        end
        else
        begin
            power_q   <= en_q && !pdown_q;
            chan_q    <= en_q ? chan_route(ch_q) : 5'h00;
            rd_data_q <= rd_en ? rd_mux : ZERO_BYTE;
        end
    end

    // ========================================================
    // Submodules.
    // ========================================================
    sarcs_tad_gen u_tad (
        .clock     (clock),
        .srst      (srst),
        .run       (running),
        .sel       (cs_q),
        .rc_osc    (rc_osc),
        .half_tick (half_tick)
    );

    sarcs_sar_core u_sar (
        .clock     (clock),
        .srst      (srst),
        .start     (core_start),
        .abort     (core_abort && running),
        .half_tick (half_tick),
        .comp_in   (comp_in),
        .busy_q    (busy),
        .sample_q  (sample_q),
        .dac_q     (dac_q),
        .done_q    (done),
        .part_q    (part),
        .res_q     (core_res)
    );

endmodule // sarcs_top

// ### tb/sarcs_monitor.sv
`timescale 1ns/100ps
module sarcs_monitor (
    input wire logic       clock,      // Clock.
    input wire logic       srst,       // Reset.
    input wire logic [3:0] addr,       // Address.
    input wire logic [7:0] wr_data,    // Write data.
    input wire logic       wr_en,      // Write.
    input wire logic       rd_en,      // Read.
    input wire logic [7:0] rd_data_q,  // Read data.
    input wire logic       sleep_mode, // Sleep.
    input wire logic       power_q,    // Power.
    input wire logic [4:0] chan_q,     // Channel.
    input wire logic       sample_q,   // Sampling.
    input wire logic       irq_q,      // Interrupt.
    input wire logic       wake_q      // Wake.
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    logic rc_q; // Last control write picked the RC clock.
    always_ff @(posedge clock)
        if (srst) rc_q <= 1'b0;
        else if (wr_en && addr == 4'h0) rc_q <= &wr_data[6:5];
    rd_idle_a: assert property (!$past(rd_en) |-> rd_data_q == 8'h00)
        else $error("read data not idle");
    chan_hot_a: assert property ($onehot0(chan_q))
        else $error("channel not one-hot");
    en_off_a: assert property (wr_en && addr == 4'h0 && !wr_data[0]
        |-> ##[1:2] !power_q) else $error("power stays on");
    wake_slp_a: assert property (wake_q |-> sleep_mode && irq_q)
        else $error("wake without cause");
    wake_one_a: assert property (wake_q |=> !wake_q)
        else $error("wake too long");
    samp_len_a: assert property ($rose(sample_q) |-> sample_q[*3])
        else $error("sampling too short");
    rst_zero_a: assert property ($fell(srst)
        |-> !power_q && !irq_q && chan_q == 5'h00) else $error("reset");
    slp_abort_a: assert property ($rose(sleep_mode) && power_q && !rc_q
        |-> ##[1:3] !power_q) else $error("sleep did not abort");
endmodule // sarcs_monitor
bind sarcs_top sarcs_monitor mon (.clock, .srst, .addr, .wr_data, .wr_en,
    .rd_en, .rd_data_q, .sleep_mode, .power_q, .chan_q, .sample_q, .irq_q,
    .wake_q);

// ### tb/sarcs_front_model.sv
`timescale 1ns/100ps
module sarcs_front_model (
    input  wire logic [7:0] dac_q,   // Trial code.
    input  wire logic [7:0] vin,     // Held input level.
    output logic            comp_in, // Input at or above trial.
    output logic            rc_osc   // Free RC clock.
);
    assign comp_in = (vin >= dac_q) === 1'b1;
    // Period unrelated to the system clock.
    initial
    begin
        rc_osc = 1'b0;
        forever #130 rc_osc = ~rc_osc;
    end
endmodule // sarcs_front_model

// ### tb/sar_converter_sequencer_test.sv
`timescale 1ns/100ps
module sar_converter_sequencer_test import sarcs_pkg::*; ;
    logic        clock = 1'b0, srst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic        sleep_mode = 1'b0, seen_q = 1'b0;
    logic        comp_in, rc_osc, power_q, sample_q, irq_q, wake_q;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wr_data = 8'h00, vin = 8'h00, rd_data_q, dac_q, last_q;
    logic [7:0]  exp_q[$], msk_q[$];
    logic [4:0]  chan_q;
    logic [4:0]  ch_exp[8] = '{5'h01, 5'h02, 5'h04, 5'h00, 5'h00, 5'h00,
                               5'h08, 5'h10};
    logic [31:0] seed = 32'hf9c2_882a;
    int          bad_count = 0, comparisons = 0, cyc = 0, n, t;
    int          div[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
    sarcs_top dut (.clock, .srst, .addr, .wr_data, .wr_en, .rd_en,
        .rd_data_q, .sleep_mode, .rc_osc, .comp_in, .power_q, .chan_q,
        .sample_q, .dac_q, .irq_q, .wake_q);
    sarcs_front_model fe (.dac_q, .vin, .comp_in, .rc_osc);
    initial forever #20 clock = ~clock;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Each access takes two cycles, so strobes never stack in one step.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, m = 8'hFF);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge clock);
        rd_en <= 1'b0;
    endtask
    // Polls the start bit; n ends as cycles since the start write.
    task automatic poll(input logic [7:0] e);
        n = 0;
        do
        begin
            rd(REG_CTRL, e, 8'hFD);
            repeat (2) @(posedge clock);
            n += 4;
        end while (last_q[GO_BIT] && n < 2000);
    endtask
    always @(posedge clock)
    begin
        if (seen_q)
        begin
            last_q = rd_data_q;
            chk("rd_data_q", exp_q.pop_front(), rd_data_q & msk_q.pop_front());
        end
        seen_q <= rd_en;
        if (++cyc == 30000)
        begin
            bad_count++;
            report_and_stop;
        end
    end
    initial
    begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        rd(REG_CTRL, CTRL_RST);
        rd(4'hF, 8'h00);
        wr(REG_CTRL, 8'h03);
        rd(REG_CTRL, 8'h01);
        for (int ch = 0; ch < 8; ch++)
        begin
            wr(REG_CTRL, {3'h0, 3'(ch), 2'b01});
            repeat (2) @(posedge clock);
            chk("chan_q", {3'h0, ch_exp[ch]}, {3'h0, chan_q});
        end
        for (int cs = 0; cs < 8; cs++)
        begin
            seed = lfsr(seed);
            vin <= seed[7:0];
            wr(REG_CTRL, {3'(cs), CH_AN1, 2'b01});
            repeat (8) @(posedge clock);
            wr(REG_CTRL, {3'(cs), CH_AN1, 2'b11});
            poll({3'(cs), CH_AN1, 2'b11});
            t = (cs % 4 == 3) ? 65 : 19 * div[cs] / 2;
            chk("time", 8'h01, {7'h0, n >= t && n <= t + 16});
            rd(REG_RESULT, seed[7:0]);
            rd(REG_FLAG, 8'h40);
            wr(REG_FLAG, 8'h00);
        end
        vin <= 8'hFF;
        wr(REG_CTRL, 8'h03);
        repeat (10) @(posedge clock);
        wr(REG_CTRL, 8'h01);
        repeat (4) @(posedge clock);
        rd(REG_RESULT, 8'hFF);
        rd(REG_FLAG, 8'h00);
        wr(REG_CTRL, 8'hC1);
        wr(REG_CTRL, 8'hC3);
        repeat (20) @(posedge clock);
        sleep_mode <= 1'b1;
        rd(REG_CTRL, 8'hC1);
        sleep_mode <= 1'b0;
        wr(REG_IEN, 8'h40);
        wr(REG_CTRL, 8'h61);
        wr(REG_CTRL, 8'h63);
        sleep_mode <= 1'b1;
        for (n = 0; n < 300 && wake_q !== 1'b1; n++) @(posedge clock);
        chk("wake_q", 8'h01, {7'h0, wake_q});
        sleep_mode <= 1'b0;
        wr(REG_IEN, 8'h00);
        wr(REG_FLAG, 8'h00);
        wr(REG_CTRL, 8'h63);
        sleep_mode <= 1'b1;
        repeat (100) @(posedge clock);
        chk("power_q", 8'h00, {7'h0, power_q});
        rd(REG_CTRL, 8'h61);
        sleep_mode <= 1'b0;
        wr(REG_RESULT, 8'h5A);
        rd(REG_RESULT, 8'h5A);
        wr(REG_CTRL, 8'h02);
        rd(REG_CTRL, 8'h00);
        wr(REG_CTRL, 8'h01);
        rd(REG_CTRL, 8'h01);
        repeat (2) @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        rd(REG_CTRL, 8'h00);
        rd(REG_RESULT, 8'h5A);
        repeat (3) @(posedge clock);
        report_and_stop;
    end
endmodule // sar_converter_sequencer_test
